// *** hdl/uitw_arb_mode.sv ***
// Purpose: derive arbiter mode outputs from the isochrony control bits
// Assumes: arbiter consumes these as levels
// Notes:   purely combinational
`timescale 1ns/1ps
module uitw_arb_mode (
  input  wire logic tableArbOn,
  input  wire logic aggrArbOn,
  output logic      useClassicArbiter,
  output logic      useTableArbiter,
  output logic      allowMidPreempt
);
  // level two only meaningful on top of level one
  assign useClassicArbiter = !tableArbOn;
  assign useTableArbiter   = tableArbOn;
  assign allowMidPreempt   = tableArbOn && aggrArbOn;
endmodule

// *** hdl/uitw_pkg.sv ***
// Purpose: shared constants for the upstream isochronous traffic-class window registers
// Assumes: avalon-mm slave, 32-bit data, byte addresses
// Notes:   offsets are byte addresses
package uitw_pkg;
  localparam int          ADDR_W          = 8;
  localparam logic [7:0]  OFF_ISOC_CTRL   = 8'h04;
  localparam logic [7:0]  OFF_WIN0_CTRL   = 8'h08;
  localparam logic [7:0]  OFF_WIN0_BASE   = 8'h0c;
  localparam logic [7:0]  OFF_WIN0_LIMIT  = 8'h10;
  localparam int          BIT_ISOC_EN     = 0;
  localparam int          BIT_TABLE_ARB   = 1;
  localparam int          BIT_AGGR_ARB    = 2;
  localparam int          BIT_WIN_EN      = 0;
  localparam int          TC_LSB          = 1;
  localparam int          TC_W            = 3;
  localparam logic [2:0]  TC_ZERO         = 3'h0;
  localparam logic [15:0] CTRL_RESET      = 16'h0000;
  localparam logic [31:0] WORD_RESET      = 32'h00000000;
  localparam logic [31:0] UNMAPPED_READ   = 32'h00000000;

  typedef enum logic [1:0] {
    UITW_IDLE = 2'b00,
    UITW_ACK  = 2'b01
  } uitw_bus_state_t;
endpackage

// *** hdl/uitw_regs.sv ***
// Purpose: register bank for isochrony control and address window 0
// Assumes: avalon-mm master holds request until waitrequest low; rst covers all reset sources
// Notes:   one wait cycle per access; answer registered
`timescale 1ns/1ps

module uitw_regs #(
  parameter int AW = 32
) (
  input  wire logic                          clk,
  input  wire logic                          rst,
  input  wire logic [uitw_pkg::ADDR_W-1:0]   avsAddress,
  input  wire logic                          avsRead,
  input  wire logic                          avsWrite,
  input  wire logic [31:0]                   avsWritedata,
  input  wire logic [3:0]                    avsByteenable,
  output logic [31:0]                        avsReaddata,
  output logic                               avsWaitrequest,
  input  wire logic [AW-1:0]                 txnAddr,
  output logic                               winHit,
  output logic [2:0]                         txnTc,
  output logic                               useClassicArbiter,
  output logic                               useTableArbiter,
  output logic                               allowMidPreempt
);

  typedef struct packed {
    uitw_pkg::uitw_bus_state_t busState;
    logic                      isocEn;
    logic                      tableArb;
    logic                      aggrArb;
    logic                      winEn;
    logic [2:0]                winTc;
    logic [31:0]               winBase;
    logic [31:0]               winLimit;
    logic [31:0]               rdData;
  } uitw_state_t;

  uitw_state_t st_reg;
  uitw_state_t st_next;

  logic        req;
  logic [31:0] wmask;
  logic [31:0] rdMux;
  logic [31:0] newWord;

  assign req = avsRead || avsWrite;

  // byte lane mask from byteenable
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wmask[i*8 +: 8] = {8{avsByteenable[i]}};
    end
  end

  // read mux; unused bits tie to zero
  always_comb begin
    rdMux = uitw_pkg::UNMAPPED_READ;
    unique case (avsAddress)
      uitw_pkg::OFF_ISOC_CTRL: begin
        rdMux[uitw_pkg::BIT_ISOC_EN]   = st_reg.isocEn;
        rdMux[uitw_pkg::BIT_TABLE_ARB] = st_reg.tableArb;
        rdMux[uitw_pkg::BIT_AGGR_ARB]  = st_reg.aggrArb;
      end
      uitw_pkg::OFF_WIN0_CTRL: begin
        rdMux[uitw_pkg::BIT_WIN_EN]                      = st_reg.winEn;
        rdMux[uitw_pkg::TC_LSB +: uitw_pkg::TC_W]        = st_reg.winTc;
      end
      uitw_pkg::OFF_WIN0_BASE:  rdMux = st_reg.winBase;
      uitw_pkg::OFF_WIN0_LIMIT: rdMux = st_reg.winLimit;
      default:                  rdMux = uitw_pkg::UNMAPPED_READ;
    endcase
  end

  always_comb begin
    st_next = st_reg;
    newWord = uitw_pkg::WORD_RESET;
    unique case (st_reg.busState)
      uitw_pkg::UITW_IDLE: begin
        // first cycle of a request: latch read data, hold waitrequest
        if (req) begin
          st_next.busState = uitw_pkg::UITW_ACK;
          st_next.rdData   = rdMux;
        end
      end
      uitw_pkg::UITW_ACK: begin
        st_next.busState = uitw_pkg::UITW_IDLE;
        if (avsWrite) begin
          unique case (avsAddress)
            uitw_pkg::OFF_ISOC_CTRL: begin
              newWord = {31'h00000000, st_reg.isocEn};
              newWord[uitw_pkg::BIT_TABLE_ARB] = st_reg.tableArb;
              newWord[uitw_pkg::BIT_AGGR_ARB]  = st_reg.aggrArb;
              newWord = (newWord & ~wmask) | (avsWritedata & wmask);
              st_next.isocEn   = newWord[uitw_pkg::BIT_ISOC_EN];
              st_next.tableArb = newWord[uitw_pkg::BIT_TABLE_ARB];
              // aggressive bit only holds while table arbitration is on
              st_next.aggrArb  = newWord[uitw_pkg::BIT_AGGR_ARB]
                                 && newWord[uitw_pkg::BIT_TABLE_ARB];
            end
            uitw_pkg::OFF_WIN0_CTRL: begin
              newWord = {28'h0000000, st_reg.winTc, st_reg.winEn};
              newWord = (newWord & ~wmask) | (avsWritedata & wmask);
              st_next.winEn = newWord[uitw_pkg::BIT_WIN_EN];
              st_next.winTc = newWord[uitw_pkg::TC_LSB +: uitw_pkg::TC_W];
            end
            uitw_pkg::OFF_WIN0_BASE:
              st_next.winBase  = (st_reg.winBase & ~wmask) | (avsWritedata & wmask);
            uitw_pkg::OFF_WIN0_LIMIT:
              st_next.winLimit = (st_reg.winLimit & ~wmask) | (avsWritedata & wmask);
            default: ;
          endcase
        end
      end
      default: st_next.busState = uitw_pkg::UITW_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      // all reset sources merged upstream into rst
      st_reg.busState <= uitw_pkg::UITW_IDLE;
      st_reg.isocEn   <= 1'b0;
      st_reg.tableArb <= 1'b0;
      st_reg.aggrArb  <= 1'b0;
      st_reg.winEn    <= 1'b0;
      st_reg.winTc    <= uitw_pkg::TC_ZERO;
      st_reg.winBase  <= uitw_pkg::WORD_RESET;
      st_reg.winLimit <= uitw_pkg::WORD_RESET;
      st_reg.rdData   <= uitw_pkg::WORD_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign avsReaddata    = st_reg.rdData;
  assign avsWaitrequest = req && (st_reg.busState != uitw_pkg::UITW_ACK);

  uitw_arb_mode u_arb (
    .tableArbOn        (st_reg.tableArb),
    .aggrArbOn         (st_reg.aggrArb),
    .useClassicArbiter (useClassicArbiter),
    .useTableArbiter   (useTableArbiter),
    .allowMidPreempt   (allowMidPreempt)
  );

  uitw_window_match #(.AW(AW)) u_match (
    .txnAddr    (txnAddr),
    .winBase    (st_reg.winBase[AW-1:0]),
    .winLimit   (st_reg.winLimit[AW-1:0]),
    .winEnable  (st_reg.winEn),
    .isocEnable (st_reg.isocEn),
    .winTc      (st_reg.winTc),
    .winHit     (winHit),
    .txnTc      (txnTc)
  );

  aggr_needs_table_a: assert property (@(posedge clk) disable iff (rst)
    st_reg.aggrArb |-> st_reg.tableArb) else $error("aggressive set without table mode");

  tc_zero_off_a: assert property (@(posedge clk) disable iff (rst)
    !st_reg.isocEn |-> (txnTc == 3'h0 && !winHit)) else $error("nonzero tc while disabled");

  window_off_a: assert property (@(posedge clk) disable iff (rst)
    !st_reg.winEn |-> !winHit) else $error("hit on disabled window");

  window_tc_a: assert property (@(posedge clk) disable iff (rst)
    (st_reg.isocEn && st_reg.winEn && txnAddr >= st_reg.winBase[AW-1:0]
     && txnAddr <= st_reg.winLimit[AW-1:0]) |-> (winHit && txnTc == st_reg.winTc))
    else $error("in-range transaction not mapped");

  classic_arb_a: assert property (@(posedge clk) disable iff (rst)
    useClassicArbiter == !useTableArbiter) else $error("arbiter mode inconsistent");

  preempt_a: assert property (@(posedge clk) disable iff (rst)
    allowMidPreempt == (st_reg.tableArb && st_reg.aggrArb)) else $error("preempt mismatch");

  wait_one_a: assert property (@(posedge clk) disable iff (rst)
    (req && st_reg.busState == uitw_pkg::UITW_IDLE) |=> (!avsWaitrequest || !req))
    else $error("waitrequest held over one cycle");

  base_write_a: assert property (@(posedge clk) disable iff (rst)
    (avsWrite && !avsWaitrequest && avsAddress == uitw_pkg::OFF_WIN0_BASE
     && avsByteenable == 4'hf) |=> (st_reg.winBase == $past(avsWritedata)))
    else $error("base write lost");

  ctrl_read_a: assert property (@(posedge clk) disable iff (rst)
    (avsRead && !avsWaitrequest && (avsAddress == uitw_pkg::OFF_ISOC_CTRL
     || avsAddress == uitw_pkg::OFF_WIN0_CTRL)) |-> (avsReaddata[31:4] == 28'h0000000))
    else $error("reserved bits nonzero");

  limit_write_a: assert property (@(posedge clk) disable iff (rst)
    (avsWrite && !avsWaitrequest && avsAddress == uitw_pkg::OFF_WIN0_LIMIT
     && avsByteenable == 4'hf) |=> (st_reg.winLimit == $past(avsWritedata)))
    else $error("limit write lost");

  tc_write_a: assert property (@(posedge clk) disable iff (rst)
    (avsWrite && !avsWaitrequest && avsAddress == uitw_pkg::OFF_WIN0_CTRL
     && avsByteenable[0]) |=> (st_reg.winTc == $past(avsWritedata[3:1])
     && st_reg.winEn == $past(avsWritedata[0])))
    else $error("window control write lost");

  isoc_write_a: assert property (@(posedge clk) disable iff (rst)
    (avsWrite && !avsWaitrequest && avsAddress == uitw_pkg::OFF_ISOC_CTRL
     && avsByteenable[0]) |=> (st_reg.isocEn == $past(avsWritedata[0])
     && st_reg.aggrArb == ($past(avsWritedata[2]) && $past(avsWritedata[1]))))
    else $error("isochrony control write lost");

  // an idle bus must never stall the master
  idle_wait_a: assert property (@(posedge clk) disable iff (rst)
    !req |-> !avsWaitrequest) else $error("waitrequest without request");

  hit_cov: cover property (@(posedge clk) disable iff (rst) winHit);
  preempt_cov: cover property (@(posedge clk) disable iff (rst) allowMidPreempt);
  write_cov: cover property (@(posedge clk) disable iff (rst) avsWrite && !avsWaitrequest);
  read_cov: cover property (@(posedge clk) disable iff (rst) avsRead && !avsWaitrequest);
endmodule

// *** hdl/uitw_window_match.sv ***
// Purpose: classify an upstream address against window 0
// Assumes: address is a level from the classifier, same clock
// Notes:   combinational; inclusive bounds
`timescale 1ns/1ps
module uitw_window_match #(
  parameter int AW = 32
) (
  input  wire logic [AW-1:0] txnAddr,
  input  wire logic [AW-1:0] winBase,
  input  wire logic [AW-1:0] winLimit,
  input  wire logic          winEnable,
  input  wire logic          isocEnable,
  input  wire logic [2:0]    winTc,
  output logic               winHit,
  output logic [2:0]         txnTc
);
  logic inRange;
  assign inRange = (txnAddr >= winBase) && (txnAddr <= winLimit);
  // disabled window has no say over traffic
  assign winHit  = inRange && winEnable && isocEnable;
  // global switch off forces everything to tc0
  assign txnTc   = winHit ? winTc : uitw_pkg::TC_ZERO;
endmodule

// *** test/uitw_regs_test.sv ***
// Purpose: self-checking bench for the isochrony control and window 0 register bank
// Assumes: avalon-mm answer after one wait cycle; rst merges all reset sources
// Notes:   bench drives every port itself; no partner model
`timescale 1ns/1ps
module uitw_regs_test;
  logic                          clk;
  logic                          rst;
  logic [uitw_pkg::ADDR_W-1:0]   avsAddress;
  logic                          avsRead;
  logic                          avsWrite;
  logic [31:0]                   avsWritedata;
  logic [3:0]                    avsByteenable;
  logic [31:0]                   avsReaddata;
  logic                          avsWaitrequest;
  logic [31:0]                   txnAddr;
  logic                          winHit;
  logic [2:0]                    txnTc;
  logic                          useClassicArbiter;
  logic                          useTableArbiter;
  logic                          allowMidPreempt;
  int                            errorCnt;
  int                            nCompared;
  int                            cycleCnt = 0;

  uitw_regs #(.AW(32)) dut_u (
    .clk(clk), .rst(rst), .avsAddress(avsAddress), .avsRead(avsRead),
    .avsWrite(avsWrite), .avsWritedata(avsWritedata), .avsByteenable(avsByteenable),
    .avsReaddata(avsReaddata), .avsWaitrequest(avsWaitrequest), .txnAddr(txnAddr),
    .winHit(winHit), .txnTc(txnTc), .useClassicArbiter(useClassicArbiter),
    .useTableArbiter(useTableArbiter), .allowMidPreempt(allowMidPreempt)
  );

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", nCompared, errorCnt);
    if (errorCnt == 0 && nCompared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ceiling well above the hundred-odd cycles the run needs
  always @(posedge clk) begin
    cycleCnt <= cycleCnt + 1;
    if (cycleCnt == 5000) begin
      errorCnt++;
      report_and_stop();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    nCompared++;
    if (seen !== exp) begin
      errorCnt++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one idle edge before each request, so a release is never re-raised at once
  task automatic busAccess(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
                           output logic [31:0] rdata);
    @(posedge clk);
    avsAddress   <= addr;
    avsWrite     <= wr;
    avsRead      <= !wr;
    avsWritedata <= wdata;
    do @(posedge clk); while (avsWaitrequest !== 1'b0);
    rdata = avsReaddata;
    avsRead  <= 1'b0;
    avsWrite <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] addr, input logic [31:0] data);
    logic [31:0] unused;
    busAccess(1'b1, addr, data, unused);
  endtask

  task automatic rdCheck(input logic [7:0] addr, input logic [31:0] exp);
    logic [31:0] got;
    busAccess(1'b0, addr, 32'h00000000, got);
    check(got, exp);
  endtask

  task automatic arbCheck(input logic c, input logic t, input logic p);
    @(negedge clk);
    check({31'h0, useClassicArbiter}, {31'h0, c});
    check({31'h0, useTableArbiter}, {31'h0, t});
    check({31'h0, allowMidPreempt}, {31'h0, p});
  endtask

  task automatic probe(input logic [31:0] addr, input logic hit, input logic [2:0] tc);
    @(posedge clk);
    txnAddr <= addr;
    @(negedge clk);
    check({31'h0, winHit}, {31'h0, hit});
    check({29'h0, txnTc}, {29'h0, tc});
  endtask

  task automatic testDefaults();
    rdCheck(8'h04, 32'h00000000);
    rdCheck(8'h08, 32'h00000000);
    rdCheck(8'h0c, 32'h00000000);
    rdCheck(8'h10, 32'h00000000);
    arbCheck(1'b1, 1'b0, 1'b0);
    probe(32'h00000000, 1'b0, 3'h0);
  endtask

  task automatic testIsocCtrl();
    wr(8'h04, 32'h0000ffff);
    rdCheck(8'h04, 32'h00000007);
    arbCheck(1'b0, 1'b1, 1'b1);
    wr(8'h04, 32'h00000005);
    rdCheck(8'h04, 32'h00000001);
    arbCheck(1'b1, 1'b0, 1'b0);
    wr(8'h04, 32'h00000003);
    arbCheck(1'b0, 1'b1, 1'b0);
  endtask

  task automatic testWindow();
    wr(8'h08, 32'h0000fffe);
    rdCheck(8'h08, 32'h0000000e);
    // window still disabled, so base and limit are plain scratch
    wr(8'h0c, 32'ha5a55a5a);
    wr(8'h10, 32'h5a5aa5a5);
    rdCheck(8'h0c, 32'ha5a55a5a);
    rdCheck(8'h10, 32'h5a5aa5a5);
    wr(8'h14, 32'hffffffff);
    rdCheck(8'h14, 32'h00000000);
    rdCheck(8'h0c, 32'ha5a55a5a);
  endtask

  task automatic testMatch();
    wr(8'h04, 32'h00000000);
    wr(8'h0c, 32'h00001000);
    wr(8'h10, 32'h00001fff);
    wr(8'h08, 32'h0000000b);
    probe(32'h00001000, 1'b0, 3'h0);
    wr(8'h04, 32'h00000001);
    probe(32'h00000fff, 1'b0, 3'h0);
    probe(32'h00001000, 1'b1, 3'h5);
    probe(32'h00001fff, 1'b1, 3'h5);
    probe(32'h00002000, 1'b0, 3'h0);
    wr(8'h08, 32'h00000007);
    probe(32'h00001800, 1'b1, 3'h3);
    wr(8'h08, 32'h0000000e);
    probe(32'h00001800, 1'b0, 3'h0);
    // base above limit leaves an empty window
    wr(8'h08, 32'h0000000b);
    wr(8'h0c, 32'h00003000);
    probe(32'h00001800, 1'b0, 3'h0);
  endtask

  task automatic testMidReset();
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rdCheck(8'h04, 32'h00000000);
    rdCheck(8'h08, 32'h00000000);
    rdCheck(8'h0c, 32'h00000000);
    rdCheck(8'h10, 32'h00000000);
    arbCheck(1'b1, 1'b0, 1'b0);
    probe(32'h00001800, 1'b0, 3'h0);
  endtask

  initial begin
    rst           = 1'b1;
    avsAddress    = 8'h00;
    avsRead       = 1'b0;
    avsWrite      = 1'b0;
    avsWritedata  = 32'h00000000;
    avsByteenable = 4'hf;
    txnAddr       = 32'h00000000;
    errorCnt      = 0;
    nCompared     = 0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    testDefaults();
    testIsocCtrl();
    testWindow();
    testMatch();
    testMidReset();
    report_and_stop();
  end
endmodule
